/* File: verilog/modem_regs_pkg.sv */
// constants shared by the modem status, special function and divisor register block
package modem_regs_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_MSR      = 6'h06;
    localparam logic [5:0] IDX_SFR      = 6'h07;
    localparam logic [5:0] IDX_DIV_LOW  = 6'h08;
    localparam logic [5:0] IDX_DIV_HIGH = 6'h09;
    localparam logic [5:0] IDX_CNT15    = 6'h0F;
    localparam logic [5:0] IDX_CNT16    = 6'h10;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
    // special function bit positions
    localparam int SFR_FORCE_TX  = 0;
    localparam int SFR_AUTO_FLOW = 1;
    localparam int SFR_EXT_MODE  = 5;
    localparam int SFR_SEL15     = 6;
    localparam int SFR_SEL16     = 7;
    // writable bits of the special function register (2 and 3 read as zero)
    localparam logic [7:0] SFR_WR_MASK = 8'hF3;
    // modem line positions within the level vector
    localparam int LINE_CTS = 0;
    localparam int LINE_DSR = 1;
    localparam int LINE_RI  = 2;
    localparam int LINE_DCD = 3;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB  = 4'h0;
    // synchroniser depth in flip-flops
    localparam int SYNC_STAGES = 2;
endpackage : modem_regs_pkg

/* File: verilog/modem_line_sync.sv */
// two-flop synchroniser for the asynchronous modem lines
`timescale 1ns/100ps
module modem_line_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] synced
);
    import modem_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // one chain per line; the first stage feeds only the second
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_line
        logic [SYNC_STAGES-1:0] chain;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                chain <= '0;
            end else begin
                chain <= {chain[SYNC_STAGES-2:0], raw[i]};
            end
        end
        assign synced[i] = chain[SYNC_STAGES-1];
    end
endmodule : modem_line_sync

/* File: verilog/baud_tick_gen.sv */
// divides the reference clock by the programmed divisor into a bit-rate tick
`timescale 1ns/100ps
module baud_tick_gen #(
    parameter int DIV_W = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  tick
);
    logic [DIV_W-1:0] count;

    ////////////////////////////////////////////////////////////////////////
    // count down from divisor-1; a zero divisor stops the tick altogether
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (divisor == '0) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count == '0) begin
            count <= divisor - 1'b1;
            tick  <= 1'b1;
        end else begin
            count <= count - 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule : baud_tick_gen

/* File: verilog/uart_modem_status_divisor_regs.sv */
// modem status, special function and baud divisor registers of one serial channel
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module uart_modem_status_divisor_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    // modem lines from the peer
    input  wire logic        cts,
    input  wire logic        dsr,
    input  wire logic        ri,
    input  wire logic        dcd,
    // modem control context
    input  wire logic        loopback_en,
    input  wire logic        gp_out1,
    input  wire logic        gp_out2,
    input  wire logic        dtr_request,
    // transmit and receive context
    input  wire logic        tx_flow_hold,
    input  wire logic        rx_has_room,
    input  wire logic [7:0]  rx_fill_count,
    input  wire logic [7:0]  line_status_count,
    input  wire logic [7:0]  tx_fill_count,
    // controls to the channel
    output logic             tx_enable,
    output logic             dtr_out,
    output logic             auto_dsr_dtr_flow,
    output logic             extended_mode,
    output logic             offset15_counter_select,
    output logic             offset16_counter_select,
    output logic      [15:0] baud_divisor,
    output logic      [7:0]  sample_clock,
    output logic             baud_tick,
    output logic             irq
);
    import modem_regs_pkg::*;

    logic [3:0] line_sync;
    logic [3:0] lvl;
    logic [3:0] lvl_prev;
    logic [3:0] ev;
    logic [3:0] msr_delta;
    logic [3:0] next_msr_delta;
    logic [7:0] sfr;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [5:0] idx;
    logic       acc_go;
    logic       acc_done;
    logic       wr_done;
    logic       hit;
    logic [7:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    // modem line capture

    modem_line_sync #(
        .WIDTH (4)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     ({dcd, ri, dsr, cts}),
        .synced  (line_sync)
    );

    // loopback replaces ring and carrier by the general outputs, which are
    // already on this clock and so skip the synchroniser
    always_comb begin
        lvl           = line_sync;
        lvl[LINE_RI]  = loopback_en ? gp_out1 : line_sync[LINE_RI];
        lvl[LINE_DCD] = loopback_en ? gp_out2 : line_sync[LINE_DCD];
    end

    // previous level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_prev <= RST_NIB;
        end else begin
            lvl_prev <= lvl;
        end
    end

    // change events; ring counts only its rising edge
    always_comb begin
        ev[LINE_CTS] = lvl[LINE_CTS] ^ lvl_prev[LINE_CTS];
        ev[LINE_DSR] = lvl[LINE_DSR] ^ lvl_prev[LINE_DSR];
        ev[LINE_RI]  = lvl[LINE_RI] & ~lvl_prev[LINE_RI];
        ev[LINE_DCD] = lvl[LINE_DCD] ^ lvl_prev[LINE_DCD];
    end

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: one wait state, answer registered

    assign idx      = paddr[7:2];
    assign acc_go   = psel & penable & ~pready;
    assign acc_done = psel & penable & pready;
    assign wr_done  = acc_done & pwrite & (paddr[1:0] == 2'b00);

    // read multiplexer and address decode
    always_comb begin
        hit    = (paddr[1:0] == 2'b00);
        rd_val = RST_BYTE;
        case (idx)
            IDX_MSR:      rd_val = {lvl, msr_delta};
            IDX_SFR:      rd_val = sfr & SFR_WR_MASK;
            IDX_DIV_LOW:  rd_val = div_low;
            IDX_DIV_HIGH: rd_val = div_high;
            IDX_CNT15:    rd_val = sfr[SFR_SEL15] ? line_status_count : rx_fill_count;
            IDX_CNT16:    rd_val = sfr[SFR_SEL16] ? tx_fill_count : sample_clock;
            IDX_IRQ_STAT: rd_val = {4'h0, irq_stat};
            IDX_IRQ_MASK: rd_val = {4'h0, irq_mask};
            default:      hit = 1'b0;
        endcase
    end

    // answer is taken in the first access cycle and shown with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_go;
            pslverr <= acc_go & ~hit;
            if (acc_go) begin
                prdata <= (hit && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modem status change flags

    // a read clears at the same edge that captures read data, so nothing
    // set afterwards is lost; a new event in that cycle wins over the clear
    always_comb begin
        next_msr_delta = msr_delta;
        if (acc_go && !pwrite && hit && idx == IDX_MSR) begin
            next_msr_delta = RST_NIB;
        end
        next_msr_delta = next_msr_delta | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msr_delta <= RST_NIB;
        end else begin
            msr_delta <= next_msr_delta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // writable registers

    // special function register; reserved bits 2 and 3 never store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sfr <= RST_BYTE;
        end else if (wr_done && idx == IDX_SFR) begin
            sfr <= pwdata[7:0] & SFR_WR_MASK;
        end
    end

    // divisor latch bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_low  <= RST_BYTE;
            div_high <= RST_BYTE;
        end else begin
            if (wr_done && idx == IDX_DIV_LOW) begin
                div_low <= pwdata[7:0];
            end
            if (wr_done && idx == IDX_DIV_HIGH) begin
                div_high <= pwdata[7:0];
            end
        end
    end

    // sample clock register only takes writes while offset 16 shows it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_clock <= RST_BYTE;
        end else if (wr_done && idx == IDX_CNT16 && !sfr[SFR_SEL16]) begin
            sample_clock <= pwdata[7:0];
        end
    end

    assign baud_divisor            = {div_high, div_low};
    assign auto_dsr_dtr_flow       = sfr[SFR_AUTO_FLOW];
    assign extended_mode           = sfr[SFR_EXT_MODE];
    assign offset15_counter_select = sfr[SFR_SEL15];
    assign offset16_counter_select = sfr[SFR_SEL16];

    ////////////////////////////////////////////////////////////////////////
    // transmit gating and terminal-ready

    // force wins over every hold; auto flow holds while the peer drops dsr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_enable <= 1'b0;
            dtr_out   <= 1'b0;
        end else begin
            tx_enable <= sfr[SFR_FORCE_TX] |
                         (~tx_flow_hold & ~(sfr[SFR_AUTO_FLOW] & ~lvl[LINE_DSR]));
            dtr_out   <= sfr[SFR_AUTO_FLOW] ? rx_has_room : dtr_request;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, mask and output

    // write one to clear; a new event in the same cycle keeps the bit set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= RST_NIB;
            irq_mask <= RST_NIB;
            irq      <= 1'b0;
        end else begin
            if (wr_done && idx == IDX_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata[3:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            if (wr_done && idx == IDX_IRQ_MASK) begin
                irq_mask <= pwdata[3:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit-rate timing

    baud_tick_gen #(
        .DIV_W (16)
    ) u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .divisor ({div_high, div_low}),
        .tick    (baud_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence msr_read_s;
        acc_go && !pwrite && paddr == {IDX_MSR, 2'b00};
    endsequence

    sequence ri_rise_s;
        ($rose(ri) && !loopback_en) ##1 (!loopback_en) [*3];
    endsequence

    cts_change_flag_a: assert property ($changed(cts) |-> ##3 msr_delta[0])
        else $error("cts change did not set flag");
    dsr_change_flag_a: assert property ($changed(dsr) |-> ##3 msr_delta[1])
        else $error("dsr change did not set flag");
    ri_rise_flag_a: assert property (ri_rise_s |-> msr_delta[2])
        else $error("ring rise did not set flag");
    ri_fall_quiet_a: assert property ($fell(lvl[2]) && !msr_delta[2] |=> !msr_delta[2])
        else $error("ring fall set flag");
    dcd_change_flag_a: assert property (!loopback_en && !$past(loopback_en)
                                        && $changed(line_sync[3]) |-> ##1 msr_delta[3])
        else $error("carrier change did not set flag");
    msr_read_clear_a: assert property (msr_read_s and (ev == 4'h0) |=> msr_delta == 4'h0)
        else $error("status read did not clear flags");
    msr_low_level_a: assert property (msr_read_s |=> prdata[5:4] == $past(lvl[1:0]))
        else $error("cts or dsr level wrong on read");
    loop_ring_a: assert property (msr_read_s and loopback_en |=> prdata[7:6] == $past({gp_out2, gp_out1}))
        else $error("loopback levels wrong on read");
    force_tx_a: assert property (sfr[0] |=> tx_enable)
        else $error("forced transmit not enabled");
    auto_flow_hold_a: assert property (sfr[1] && !sfr[0] && !lvl[1] |=> !tx_enable)
        else $error("auto flow did not hold transmit");
    cnt15_select_a: assert property (acc_go && !pwrite && paddr == {IDX_CNT15, 2'b00} && sfr[6]
                                     |=> prdata[7:0] == $past(line_status_count))
        else $error("offset 15 select wrong");
    div_low_write_a: assert property (wr_done && idx == IDX_DIV_LOW |=> baud_divisor[7:0] == $past(pwdata[7:0]))
        else $error("divisor low not stored");
    irq_level_a: assert property (|(irq_stat & irq_mask) |=> irq)
        else $error("interrupt not raised");
    cnt16_select_a: assert property (acc_go && !pwrite && paddr == {IDX_CNT16, 2'b00} && sfr[7]
                                     |=> prdata[7:0] == $past(tx_fill_count))
        else $error("offset 16 select wrong");
    div_high_write_a: assert property (wr_done && idx == IDX_DIV_HIGH
                                       |=> baud_divisor[15:8] == $past(pwdata[7:0]))
        else $error("divisor high not stored");
    ext_mode_write_a: assert property (wr_done && idx == IDX_SFR
                                       |=> extended_mode == $past(pwdata[SFR_EXT_MODE]))
        else $error("mode bit not stored");
    msr_write_quiet_a: assert property (wr_done && idx == IDX_MSR && ev == 4'h0
                                        |=> msr_delta == $past(msr_delta))
        else $error("status write changed flags");
    tick_stop_a: assert property (baud_divisor == 16'h0000 |=> !baud_tick)
        else $error("tick with zero divisor");
    refused_access_a: assert property (acc_go && !hit |=> pslverr && prdata == 32'h0000_0000)
        else $error("refused access not flagged");
    auto_dtr_a: assert property (sfr[1] |=> dtr_out == $past(rx_has_room))
        else $error("terminal-ready not following room");
    manual_dtr_a: assert property (!sfr[1] |=> dtr_out == $past(dtr_request))
        else $error("terminal-ready not following request");
    flow_free_a: assert property (!sfr[1] && !tx_flow_hold |=> tx_enable)
        else $error("transmit held without cause");
    irq_clear_a: assert property (wr_done && idx == IDX_IRQ_STAT && pwdata[0] && !ev[0] |=> !irq_stat[0])
        else $error("interrupt status not cleared");

    // looped lines skip the synchroniser, so their flags follow one cycle later
    sequence ring_loop_rise_s;
        loopback_en && $past(loopback_en) && $rose(gp_out1);
    endsequence

    ring_loop_rise_a: assert property (ring_loop_rise_s |=> msr_delta[2])
        else $error("looped ring rise did not set flag");
    carrier_loop_a: assert property (loopback_en && $past(loopback_en) && $changed(gp_out2) |=> msr_delta[3])
        else $error("looped carrier change did not set flag");
endmodule : uart_modem_status_divisor_regs

/* File: bench/modem_peer.sv */
// behavioural serial peer that drives the four modem status lines
`timescale 1ns/100ps
module modem_peer (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] want,
    input  wire logic       slow,
    output logic            cts,
    output logic            dsr,
    output logic            ri,
    output logic            dcd
);
    logic [3:0] lag1;
    logic [3:0] lag2;
    ////////////////////////////////////////////////////////////////
    // a slow peer settles its lines one cycle later than a prompt one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lag1 <= 4'h0;
            lag2 <= 4'h0;
        end else begin
            lag1 <= want;
            lag2 <= lag1;
        end
    end
    // lines change only just after an edge, never mid-cycle
    assign {dcd, ri, dsr, cts} = slow ? lag2 : lag1;
endmodule : modem_peer

/* File: bench/uart_modem_status_divisor_regs_tb.sv */
// self-checking bench for the modem status, special function and divisor registers
`timescale 1ns/100ps
module uart_modem_status_divisor_regs_tb;
    import modem_regs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cts, dsr, ri, dcd, slow, er;
    logic        loopback_en, gp_out1, gp_out2, dtr_request, tx_flow_hold, rx_has_room, tx_enable;
    logic        dtr_out, auto_dsr_dtr_flow, extended_mode, offset15_counter_select;
    logic        offset16_counter_select, baud_tick, irq;
    logic [7:0]  paddr, rx_fill_count, line_status_count, tx_fill_count, sample_clock, v, w, sc;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [15:0] baud_divisor;
    logic [3:0]  want, old_lv, new_lv;
    int          err_count, checked, ticks;

    uart_modem_status_divisor_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .cts, .dsr, .ri, .dcd, .loopback_en, .gp_out1, .gp_out2,
        .dtr_request, .tx_flow_hold, .rx_has_room, .rx_fill_count, .line_status_count,
        .tx_fill_count, .tx_enable, .dtr_out, .auto_dsr_dtr_flow, .extended_mode,
        .offset15_counter_select, .offset16_counter_select, .baud_divisor, .sample_clock,
        .baud_tick, .irq);
    modem_peer peer (.pclk, .presetn, .want, .slow, .cts, .dsr, .ri, .dcd);

    ////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("checks=%0d errors=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask : idle

    // one apb transfer; the wait for pready is bounded
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // change flags: either direction, except ring which counts rises only
    function automatic logic [3:0] flg_exp(input logic [3:0] o, input logic [3:0] n);
        return {o[3] ^ n[3], ~o[2] & n[2], o[1] ^ n[1], o[0] ^ n[0]};
    endfunction : flg_exp

    // lines are parked low first, else a high line would flag after release
    task automatic do_reset();
        want    <= 4'h0;
        idle(6);
        presetn <= 1'b0;
        idle(16);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 6; i < 10; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
    endtask : do_reset

    ////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, slow, loopback_en, gp_out1, gp_out2} = 8'h00;
        {dtr_request, tx_flow_hold, rx_has_room, paddr, pwdata, want} = 47'h0;
        {rx_fill_count, line_status_count, tx_fill_count, sc} = 32'h0000_0000;
        seed = 32'h9590_32fd;
        err_count = 0;
        checked = 0;
        do_reset();
        // single-line rises then falls, then random patterns, peer speed random
        for (int i = 0; i < 16; i++) begin
            old_lv = want;
            new_lv = (i < 8) ? (want ^ (4'h1 << i[1:0])) : 4'($random(seed));
            want <= new_lv;
            slow <= 1'($random(seed));
            idle(8);
            apb(1'b1, 8'h18, 32'h0000_00ff);
            apb(1'b0, 8'h18, 32'h0000_0000);
            chk(rd, {24'h00_0000, new_lv, flg_exp(old_lv, new_lv)});
            apb(1'b0, 8'h18, 32'h0000_0000);
            chk(rd, {24'h00_0000, new_lv, 4'h0});
        end
        // loopback: general outputs replace ring and carrier
        gp_out1     <= want[2];
        gp_out2     <= want[3];
        loopback_en <= 1'b1;
        idle(4);
        apb(1'b0, 8'h18, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            old_lv = {gp_out2, gp_out1, want[1:0]};
            new_lv = {2'($random(seed)), want[1:0]};
            gp_out1 <= new_lv[2];
            gp_out2 <= new_lv[3];
            idle(4);
            apb(1'b0, 8'h18, 32'h0000_0000);
            chk(rd, {24'h00_0000, new_lv, flg_exp(old_lv, new_lv)});
        end
        loopback_en <= 1'b0;
        idle(6);
        apb(1'b0, 8'h18, 32'h0000_0000);
        // special function bits, counter selects and flow controls
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            w = 8'($random(seed));
            {tx_flow_hold, rx_has_room, dtr_request} <= 3'($random(seed));
            {rx_fill_count, line_status_count, tx_fill_count} <= 24'($random(seed));
            apb(1'b1, 8'h1c, {24'h00_0000, v});
            apb(1'b1, 8'h40, {24'h00_0000, w});
            if (!v[7]) sc = w;
            apb(1'b0, 8'h1c, 32'h0000_0000);
            chk(rd, {24'h00_0000, v & SFR_WR_MASK});
            chk({28'h000_0000, offset16_counter_select, offset15_counter_select,
                 extended_mode, auto_dsr_dtr_flow}, {28'h000_0000, v[7], v[6], v[5], v[1]});
            apb(1'b0, 8'h3c, 32'h0000_0000);
            chk(rd, {24'h00_0000, v[6] ? line_status_count : rx_fill_count});
            apb(1'b0, 8'h40, 32'h0000_0000);
            chk(rd, {24'h00_0000, v[7] ? tx_fill_count : sc});
            chk({24'h00_0000, sample_clock}, {24'h00_0000, sc});
            chk({31'h0000_0000, tx_enable},
                {31'h0000_0000, v[0] | (!tx_flow_hold & !(v[1] & !want[1]))});
            chk({31'h0000_0000, dtr_out}, {31'h0000_0000, v[1] ? rx_has_room : dtr_request});
        end
        // divisor bytes read back and reach the baud generator
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            w = 8'($random(seed));
            apb(1'b1, 8'h20, {24'h00_0000, v});
            apb(1'b1, 8'h24, {24'h00_0000, w});
            apb(1'b0, 8'h20, 32'h0000_0000);
            chk(rd, {24'h00_0000, v});
            apb(1'b0, 8'h24, 32'h0000_0000);
            chk(rd, {24'h00_0000, w});
            chk({16'h0000, baud_divisor}, {16'h0000, w, v});
        end
        // a divisor of five gives ten ticks in any fifty cycles; zero stops it
        for (int d = 5; d >= 0; d -= 5) begin
            // a zero divisor first, else a long count left by the random divisors runs on
            apb(1'b1, 8'h20, 32'h0000_0000);
            apb(1'b1, 8'h24, 32'h0000_0000);
            apb(1'b1, 8'h20, 32'(d));
            idle(12);
            ticks = 0;
            repeat (50) begin
                @(posedge pclk);
                if (baud_tick === 1'b1) ticks++;
            end
            chk(32'(ticks), 32'(d * 2));
        end
        // interrupt: raised when unmasked, cleared by writing one, held off by the mask
        apb(1'b1, 8'h84, 32'h0000_0001);
        apb(1'b1, 8'h80, 32'h0000_000f);
        idle(3);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        want <= want ^ 4'h1;
        idle(8);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        apb(1'b0, 8'h80, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'b1, 8'h80, 32'h0000_0001);
        idle(3);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        apb(1'b1, 8'h84, 32'h0000_0000);
        want <= want ^ 4'h2;
        idle(8);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        apb(1'b0, 8'h80, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        // unmapped and misaligned accesses are refused
        apb(1'b0, 8'h2c, 32'h0000_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 8'h1d, 32'h0000_00ff);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        // a second reset after registers were written
        do_reset();
        complete_run();
    end
endmodule : uart_modem_status_divisor_regs_tb
